// File: pkg/timer_defines.svh
// Purpose: register offsets, field positions, reset values and timing counts of the timer
// Assumes: byte-wide registers on a plain strobe port
// Notes: definitions only
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_PRESCALER_VALUE 8'hd2
`define ADDR_COUNTER_VALUE 8'hd3
`define ADDR_TIMER_STATUS_CONTROL 8'hd4
`define ADDR_IRQ_STATUS 8'hd5
`define ADDR_IRQ_MASK 8'hd6

`define RST_PRESCALER_VALUE 7'h7f
`define RST_COUNTER_VALUE 8'hff
`define RST_TIMER_STATUS_CONTROL 8'h00

`define BIT_UNDERFLOW 7
`define BIT_INT_ENABLE 6
`define BIT_PIN_DIR 5
`define BIT_DATA_OUT 4
`define BIT_RUN 3
`define TAP_MSB 2
`define TAP_LSB 0

`define IRQ_BIT_UNDERFLOW 0
`define IRQ_BIT_PIN_EDGE 1

`define CLOCK_PERIOD_NS 50
`define INT_DIVIDE 12

`endif

// File: pkg/timer_pkg.sv
// Purpose: types shared by the timer design
// Assumes: nothing beyond the defines header
// Notes: modes follow the direction and data bits
`default_nettype none
package timer_pkg;
	typedef enum logic [1:0] {
		mode_event_count = 2'h0,
		mode_gated = 2'h1,
		mode_out_low = 2'h3,
		mode_out_high = 2'h2
	} timer_mode_t;
endpackage : timer_pkg
`default_nettype wire

// File: logic/fint_divider.sv
// Purpose: one-cycle tick every INT_DIVIDE clocks (internal frequency / 12)
// Assumes: single clock, synchronous reset
// Notes: tick is registered
`include "timer_defines.svh"
`default_nettype none
module fint_divider (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Tick out
	output logic tick_q
);
	logic [3:0] cnt_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 4'h0;
			tick_q <= 1'b0;
		end else if (cnt_q == 4'(`INT_DIVIDE - 1)) begin
			cnt_q <= 4'h0;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			tick_q <= 1'b0;
		end
	end
endmodule : fint_divider
`default_nettype wire

// File: logic/prescaled_down_timer.sv
// Purpose: 8-bit down-counter behind a 7-bit prescaler with timer pin modes
// Assumes: one clock mclk, synchronous active-high reset rst
// Notes: extra irq status/mask registers sit at 0xd5 and 0xd6
//
// The implementer's own choice: the address-and-strobe port.
`include "timer_defines.svh"
`default_nettype none
module prescaled_down_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata_q,
	// Timer pin
	input wire logic timer_pin_in,
	output logic timer_pin_out_q,
	output logic timer_pin_oe_q,
	// Interrupts
	output logic timer_irq_q,
	output logic wakeup_q,
	output logic irq_q
);
	// Pin sampling
	logic pin_meta_q;
	logic pin_sync_q;
	logic pin_prev_q;
	// Timer state
	logic fint_tick;
	logic [6:0] presc_q;
	logic [7:0] count_q;
	// Control register fields
	logic flag_q;
	logic ie_q;
	logic dir_q;
	logic dout_q;
	logic run_q;
	logic [2:0] tap_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic src_tick;
	logic pin_rise;
	logic tap_tick;
	logic underflow;
	logic flag_rise;
	logic flag_prev_q;
	logic wr_ctl;
	logic wr_cnt;
	logic wr_psc;
	timer_pkg::timer_mode_t mode;
	// Irq status sources and strobes
	logic [1:0] irq_event;
	logic wr_stat;
	logic wr_mask;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction : hit

	// Tap n fires on source ticks where the low n prescaler bits are zero
	function automatic logic tap_fire(input logic [6:0] p, input logic [2:0] n);
		logic [6:0] m;
		case (n)
			3'h0: m = 7'h00;
			3'h1: m = 7'h01;
			3'h2: m = 7'h03;
			3'h3: m = 7'h07;
			3'h4: m = 7'h0f;
			3'h5: m = 7'h1f;
			3'h6: m = 7'h3f;
			3'h7: m = 7'h7f;
			default: m = 7'h00;
		endcase
		tap_fire = ((p & m) == 7'h00);
	endfunction : tap_fire

	// Register write strobes
	assign wr_ctl = wr_en && hit(addr, `ADDR_TIMER_STATUS_CONTROL);
	assign wr_cnt = wr_en && hit(addr, `ADDR_COUNTER_VALUE);
	assign wr_psc = wr_en && hit(addr, `ADDR_PRESCALER_VALUE);

	// Internal tick, one in twelve clocks
	fint_divider u_fint (
		.mclk(mclk),
		.rst(rst),
		.tick_q(fint_tick)
	);

	// Pin synchroniser
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= timer_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Edge detect stage, reads only the synchronised pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_sync_q;
		end
	end

	// Rising edge of the synchronised pin; mode from direction and data
	assign pin_rise = pin_sync_q && !pin_prev_q;
	assign mode = timer_pkg::timer_mode_t'({dir_q, dir_q ^ dout_q});

	// Prescaler clock source per mode
	always_comb begin
		case (mode)
			timer_pkg::mode_event_count: src_tick = pin_rise;
			timer_pkg::mode_gated: src_tick = fint_tick && pin_sync_q;
			timer_pkg::mode_out_low: src_tick = fint_tick;
			timer_pkg::mode_out_high: src_tick = fint_tick;
			default: src_tick = 1'b0;
		endcase
	end

	// Counter clock from the selected tap; a write to the counter blocks the underflow
	assign tap_tick = run_q && src_tick && tap_fire(presc_q, tap_q);
	assign underflow = tap_tick && (count_q == 8'h00) && !wr_cnt;

	// Prescaler
	always_ff @(posedge mclk) begin
		if (rst) begin
			presc_q <= `RST_PRESCALER_VALUE;
		end else if (!run_q) begin
			presc_q <= `RST_PRESCALER_VALUE;
		end else if (wr_psc) begin
			presc_q <= wdata[6:0];
		end else if (src_tick) begin
			presc_q <= presc_q - 7'h01;
		end
	end

	// Counter; a write wins over a decrement
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_q <= `RST_COUNTER_VALUE;
		end else if (wr_cnt) begin
			count_q <= wdata;
		end else if (tap_tick) begin
			count_q <= count_q - 8'h01;
		end
	end

	// Control bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			ie_q <= 1'b0;
			dir_q <= 1'b0;
			dout_q <= 1'b0;
			run_q <= 1'b0;
			tap_q <= 3'h0;
		end else if (wr_ctl) begin
			ie_q <= wdata[`BIT_INT_ENABLE];
			dir_q <= wdata[`BIT_PIN_DIR];
			dout_q <= wdata[`BIT_DATA_OUT];
			run_q <= wdata[`BIT_RUN];
			tap_q <= wdata[`TAP_MSB:`TAP_LSB];
		end
	end

	// Underflow flag: hardware only sets, set beats a software clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (underflow) begin
			flag_q <= 1'b1;
		end else if (wr_ctl) begin
			flag_q <= wdata[`BIT_UNDERFLOW];
		end
	end

	// Edge detect on the flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_prev_q <= 1'b0;
		end else begin
			flag_prev_q <= flag_q;
		end
	end

	assign flag_rise = flag_q && !flag_prev_q;

	// Timer pin enable follows the direction bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_pin_oe_q <= 1'b0;
		end else begin
			timer_pin_oe_q <= dir_q;
		end
	end

	// Timer pin level changes only on a flag rise
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_pin_out_q <= 1'b0;
		end else if (flag_rise) begin
			timer_pin_out_q <= dout_q;
		end
	end

	// Interrupt sources, one status bit each
	assign irq_event[`IRQ_BIT_UNDERFLOW] = flag_rise;
	assign irq_event[`IRQ_BIT_PIN_EDGE] = pin_rise;
	assign wr_stat = wr_en && hit(addr, `ADDR_IRQ_STATUS);
	assign wr_mask = wr_en && hit(addr, `ADDR_IRQ_MASK);

	// Irq mask
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_mask_q <= 2'h0;
		end else if (wr_mask) begin
			irq_mask_q <= wdata[1:0];
		end
	end

	// Sticky irq status, write one to clear, set wins
	for (genvar g = 0; g < 2; g++) begin : g_irq_stat
		always_ff @(posedge mclk) begin
			if (rst) begin
				irq_stat_q[g] <= 1'b0;
			end else if (irq_event[g]) begin
				irq_stat_q[g] <= 1'b1;
			end else if (wr_stat && wdata[g]) begin
				irq_stat_q[g] <= 1'b0;
			end
		end
	end

	// Timer request, held while enable and flag are both set
	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_irq_q <= 1'b0;
		end else begin
			timer_irq_q <= ie_q && flag_q;
		end
	end

	// Wake-up request for the low-power states
	always_ff @(posedge mclk) begin
		if (rst) begin
			wakeup_q <= 1'b0;
		end else begin
			wakeup_q <= ie_q && flag_q;
		end
	end

	// Summary irq over the unmasked status bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				`ADDR_PRESCALER_VALUE: rdata_q <= {1'b0, presc_q};
				`ADDR_COUNTER_VALUE: rdata_q <= count_q;
				`ADDR_TIMER_STATUS_CONTROL: rdata_q <= {flag_q, ie_q, dir_q, dout_q,
					run_q, tap_q};
				`ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_stat_q};
				`ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
endmodule : prescaled_down_timer
`default_nettype wire

// File: verification/timer_pin_src.sv
// Purpose: outside source on the timer pin
// Assumes: lvl is set by the bench
// Notes: the block's drive wins while enabled
`default_nettype none
module timer_pin_src (
	// Pin
	input wire logic oe,
	input wire logic dout,
	input wire logic lvl,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin = oe ? dout : lvl;
endmodule : timer_pin_src
`default_nettype wire

// File: verification/prescaled_down_timer_props.sv
// Purpose: port checks for the timer
// Assumes: one clock, reset high
// Notes: bound below
`default_nettype none
module timer_props (
	// Clock, reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata_q,
	// Pin, requests
	input wire logic timer_pin_in,
	input wire logic timer_pin_out_q,
	input wire logic timer_pin_oe_q,
	input wire logic timer_irq_q,
	input wire logic wakeup_q,
	input wire logic irq_q
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	wire ctl = wr_en && addr == 8'hd4;
	wake_same_a: assert property (wakeup_q == timer_irq_q)
		else $error("wake differs");
	psc_top_a: assert property (rd_en && addr == 8'hd2 |=> !rdata_q[7])
		else $error("bit 7 set");
	unmapped_a: assert property (rd_en && addr > 8'hd6 |=> rdata_q == 8'h00)
		else $error("unmapped data");
	pin_in_a: assert property (ctl && !wdata[5] |-> ##2 !timer_pin_oe_q)
		else $error("pin driven");
	pin_out_a: assert property (ctl && wdata[5] |-> ##2 timer_pin_oe_q)
		else $error("pin not driven");
	irq_off_a: assert property (ctl && !wdata[6] ##1 !ctl |=> !timer_irq_q)
		else $error("request while off");
	irq_on_a: assert property (ctl && wdata[7:6] == 2'h3 ##1 !ctl |=> timer_irq_q)
		else $error("no request");
	reset_quiet_a: assert property ($fell(rst) |-> !timer_pin_oe_q && !timer_irq_q)
		else $error("active after reset");
	cover property ($rose(timer_irq_q));
	cover property ($rose(irq_q));
	cover property ($rose(timer_pin_oe_q));
endmodule : timer_props
bind prescaled_down_timer timer_props timer_props_inst (.mclk, .rst, .addr, .wdata, .wr_en,
	.rd_en, .rdata_q, .timer_pin_in, .timer_pin_out_q, .timer_pin_oe_q, .timer_irq_q,
	.wakeup_q, .irq_q);
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the timer
// Assumes: 20 MHz mclk
// Notes: pin model drives the pin
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0, lvl = 1'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_q, rv, a;
	logic timer_pin_in, po, oe, tirq, wakeup_q, irq_q;
	int failures = 0, check_count = 0, cyc = 0;
	prescaled_down_timer prescaled_down_timer_inst (.mclk, .rst, .addr, .wdata, .wr_en,
		.rd_en, .rdata_q, .timer_pin_in, .timer_pin_out_q(po), .timer_pin_oe_q(oe),
		.timer_irq_q(tirq), .wakeup_q, .irq_q);
	timer_pin_src timer_pin_src_inst (.oe, .dout(po), .lvl, .pin(timer_pin_in));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		wr_en <= 1'h1;
		addr <= ad;
		wdata <= d;
		@(posedge mclk);
		wr_en <= 1'h0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		rd_en <= 1'h1;
		addr <= ad;
		@(posedge mclk);
		rd_en <= 1'h0;
		@(negedge mclk);
		rv = rdata_q;
		@(posedge mclk);
	endtask : rd
	task automatic wait_irq;
		for (int n = 0; n < 4000 && tirq !== 1'h1; n++)
			@(posedge mclk);
		@(posedge mclk);
	endtask : wait_irq
	task automatic t_regs;
		wr(8'hd2, 8'h11);
		rd(8'hd2);
		chk("prescaler", 8'h7f, rv);
		rd(8'hd3);
		chk("counter", 8'hff, rv);
		rd(8'hd4);
		chk("control", 8'h00, rv);
		rd(8'he0);
		chk("unmapped", 8'h00, rv);
		chk("pin enable", 8'h00, {7'h00, oe});
	endtask : t_regs
	task automatic t_taps;
		lvl <= 1'h1;
		for (int n = 0; n < 8; n++) begin
			wr(8'hd4, 8'h18 | 8'(n));
			rd(8'hd3);
			a = rv;
			repeat ((48 << n) - 2) @(posedge mclk);
			rd(8'hd3);
			chk("steps", 8'h04, a - rv);
		end
	endtask : t_taps
	task automatic t_event;
		wr(8'hd4, 8'h08);
		wr(8'hd2, 8'ha5);
		rd(8'hd3);
		a = rv;
		repeat (5) begin
			lvl <= 1'h0;
			repeat (4) @(posedge mclk);
			lvl <= 1'h1;
			repeat (4) @(posedge mclk);
		end
		repeat (4) @(posedge mclk);
		rd(8'hd3);
		chk("events", 8'h05, a - rv);
		rd(8'hd2);
		chk("prescaler run", 8'h20, rv);
	endtask : t_event
	task automatic t_output;
		wr(8'hd6, 8'h01);
		wr(8'hd4, 8'h78);
		wr(8'hd3, 8'h02);
		wait_irq();
		chk("outputs", 8'h1f, {3'h0, tirq, wakeup_q, irq_q, oe, po});
		rd(8'hd4);
		chk("flag", 8'hf8, rv);
		rd(8'hd5);
		chk("status", 8'h03, rv);
		wr(8'hd4, 8'h68);
		wr(8'hd5, 8'h01);
		repeat (2) @(posedge mclk);
		chk("cleared", 8'h03, {tirq, irq_q, oe, po});
		rd(8'hd5);
		chk("status cleared", 8'h02, rv);
		wait_irq();
		chk("new level", 8'h02, {oe, po});
		wr(8'hd4, 8'ha8);
		repeat (200) @(posedge mclk);
		rd(8'hd4);
		chk("kept", 8'ha8, {rv[7:1], tirq});
		wr(8'hd4, 8'hc0);
		@(negedge mclk);
		chk("request", 8'h01, tirq);
		repeat (3) @(posedge mclk);
	endtask : t_output
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		t_regs();
		t_taps();
		t_event();
		t_output();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
